// ===== lwcp_consts.svh
// constants of the permutation core: counts, paddings, known answers
`ifndef LWCP_CONSTS_SVH
`define LWCP_CONSTS_SVH

`define LWCP_HALF        32
`define LWCP_ROT_AND     5
`define LWCP_ROT_XOR     1
`define LWCP_ROUND_FIRST 3'h0
`define LWCP_ROUND_LAST  3'h7
`define LWCP_ROUND_INC   3'h1
`define LWCP_STEP_FIRST  4'h0
`define LWCP_STEP_LAST   4'hF
`define LWCP_STEP_INC    4'h1
`define LWCP_LFSR_INIT   7'h7F
`define LWCP_RC_PAD      31'h7FFFFFFF
`define LWCP_SC_PAD      56'hFFFFFFFFFFFFFF

`define LWCP_KAT_SC0     8'h50
`define LWCP_KAT_SC1     8'h28
`define LWCP_KAT_SC2     8'h14
`define LWCP_KAT_RC0     8'h07
`define LWCP_KAT_RC1     8'h53
`define LWCP_KAT_BOX1    64'hFFFFFFFF00000000
`define LWCP_KAT_BOX8    64'h00001C1E00000C2D
`define LWCP_KAT_STEP1   64'hFFFFC7CAFFFFE776
`define LWCP_KAT_FINAL   64'h5C93691AD5060935

`endif

// ===== lwcp_pkg.sv
// types shared by the permutation core and its constant generator
package lwcp_pkg;

    typedef struct packed {
        logic [63:0] a;
        logic [63:0] b;
        logic [63:0] c;
        logic [63:0] d;
        logic [63:0] e;
    } lwcp_state_t;

    typedef struct packed {
        logic [7:0] sc2;
        logic [7:0] sc1;
        logic [7:0] sc0;
        logic [2:0] rc;
    } lwcp_const_t;

    typedef enum logic {
        LWCP_IDLE,
        LWCP_RUN
    } lwcp_mode_t;

endpackage

// ===== lwcp_const_gen.sv
// shift-register sequence giving round and step constants, 3 bits a cycle
`include "lwcp_consts.svh"

module lwcp_const_gen (
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic                 restart,
    input  wire logic                 advance,
    output lwcp_pkg::lwcp_const_t     k
);

    logic [6:0] lfsr;
    logic [6:0] next_lfsr;
    logic [9:0] win;

    // ------------------------------------------------------------
    // ten-bit window: seven state bits then three feedback bits
    // ------------------------------------------------------------
    assign win[6:0] = lfsr;
    for (genvar g = 0; g < 3; g++) begin : g_fb
        assign win[7 + g] = win[g] ^ win[g + 1];
    end

    assign k.rc  = win[2:0];
    assign k.sc0 = win[7:0];
    assign k.sc1 = win[8:1];
    assign k.sc2 = win[9:2];

    always_comb begin
        next_lfsr = lfsr;
        if (restart) begin
            next_lfsr = `LWCP_LFSR_INIT;
        end else if (advance) begin
            next_lfsr = win[9:3];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            lfsr <= `LWCP_LFSR_INIT;
        end else begin
            lfsr <= next_lfsr;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_lfsr_reload: assert property (
        @(posedge mclk) disable iff (rst)
        restart |=> (lfsr == `LWCP_LFSR_INIT) && (k.rc == 3'h7))
        else $error("sequence not reloaded with ones");

    a_rc_window: assert property (
        @(posedge mclk) disable iff (rst)
        (advance && !restart) |=> k.rc == $past(win[5:3]))
        else $error("round constant bits not from window tail");

endmodule

// ===== lwcp_core.sv
// permutation core: three boxes, one round a clock, sixteen steps
//
// What this block does
// - reload constant sequence with all ones at every permutation start.
// - each cycle, take first three window bits as that round's constants.
// - window of cycle seven of a step gives that step's step constants.
// - step zero step constants are 0x50, 0x28 and 0x14.
// - step zero round constants collected over eight rounds: 0x07, 0x53.
// - zero box input, constant seven: known first and eighth round output.
// - zero state: known first word after step one and after all steps.
`include "lwcp_consts.svh"

module lwcp_core (
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic                 start,
    input  wire lwcp_pkg::lwcp_state_t state_in,
    output logic                      busy,
    output logic                      done,
    output lwcp_pkg::lwcp_state_t     state_out
);

    // ------------------------------------------------------------
    // box round
    // ------------------------------------------------------------
    function automatic logic [31:0] rol(input logic [31:0] x, input int n);
        rol = (x << n) | (x >> (`LWCP_HALF - n));
    endfunction

    function automatic logic [63:0] box_round(input logic [63:0] x,
                                              input logic        rcb);
        logic [31:0] l;
        logic [31:0] r;
        logic [31:0] f;
        l = x[63:32];
        r = x[31:0];
        f = (l & rol(l, `LWCP_ROT_AND)) ^ rol(l, `LWCP_ROT_XOR);
        box_round = {f ^ r ^ {`LWCP_RC_PAD, rcb}, l};
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    lwcp_pkg::lwcp_mode_t  mode;
    lwcp_pkg::lwcp_mode_t  next_mode;
    lwcp_pkg::lwcp_state_t next_state_out;
    lwcp_pkg::lwcp_const_t k;
    logic [2:0]            round;
    logic [2:0]            next_round;
    logic [3:0]            step;
    logic [3:0]            next_step;
    logic                  next_busy;
    logic                  next_done;
    logic                  go;
    logic                  running;
    logic                  last_round;
    logic [63:0]           box_a;
    logic [63:0]           box_c;
    logic [63:0]           box_e;
    logic [63:0]           mix_b;
    logic [63:0]           mix_d;
    logic [63:0]           mix_e;

    // helper state read only by the checks
    logic [7:0]            rc_acc0;
    logic [7:0]            rc_acc1;
    logic [7:0]            next_rc_acc0;
    logic [7:0]            next_rc_acc1;

    assign go         = (mode == lwcp_pkg::LWCP_IDLE) && start;
    assign running    = (mode == lwcp_pkg::LWCP_RUN);
    assign last_round = (round == `LWCP_ROUND_LAST);

    lwcp_const_gen u_const (
        .mclk    (mclk),
        .rst     (rst),
        .restart (go),
        .advance (running),
        .k       (k)
    );

    // ------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------
    always_comb begin
        box_a = box_round(state_out.a, k.rc[0]);
        box_c = box_round(state_out.c, k.rc[1]);
        box_e = box_round(state_out.e, k.rc[2]);
        mix_b = state_out.b ^ box_c ^ {`LWCP_SC_PAD, k.sc0};
        mix_d = state_out.d ^ box_e ^ {`LWCP_SC_PAD, k.sc1};
        mix_e = box_e ^ box_a ^ {`LWCP_SC_PAD, k.sc2};
    end

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_mode      = mode;
        next_state_out = state_out;
        next_round     = round;
        next_step      = step;
        next_busy      = busy;
        next_done      = done;
        next_rc_acc0   = rc_acc0;
        next_rc_acc1   = rc_acc1;
        case (mode)
            lwcp_pkg::LWCP_IDLE: begin
                if (start) begin
                    next_mode      = lwcp_pkg::LWCP_RUN;
                    next_state_out = state_in;
                    next_round     = `LWCP_ROUND_FIRST;
                    next_step      = `LWCP_STEP_FIRST;
                    next_busy      = 1'b1;
                    next_done      = 1'b0;
                end
            end
            lwcp_pkg::LWCP_RUN: begin
                if (step == `LWCP_STEP_FIRST) begin
                    next_rc_acc0[round] = k.rc[0];
                    next_rc_acc1[round] = k.rc[1];
                end
                if (last_round) begin
                    // step end: mixing, then word shuffle (d,c,a,e,b)
                    next_state_out = '{a: mix_d, b: box_c, c: box_a,
                                       d: mix_e, e: mix_b};
                    next_round     = `LWCP_ROUND_FIRST;
                    next_step      = step + `LWCP_STEP_INC;
                    if (step == `LWCP_STEP_LAST) begin
                        next_mode = lwcp_pkg::LWCP_IDLE;
                        next_busy = 1'b0;
                        next_done = 1'b1;
                    end
                end else begin
                    next_state_out = '{a: box_a, b: state_out.b, c: box_c,
                                       d: state_out.d, e: box_e};
                    next_round     = round + `LWCP_ROUND_INC;
                end
            end
            default: begin
                next_mode = lwcp_pkg::LWCP_IDLE;
                next_busy = 1'b0;
            end
        endcase
    end

    // result stays in state_out while idle until the next start
    always_ff @(posedge mclk) begin
        if (rst) begin
            mode      <= lwcp_pkg::LWCP_IDLE;
            state_out <= '0;
            round     <= `LWCP_ROUND_FIRST;
            step      <= `LWCP_STEP_FIRST;
            busy      <= 1'b0;
            done      <= 1'b0;
            rc_acc0   <= '0;
            rc_acc1   <= '0;
        end else begin
            mode      <= next_mode;
            state_out <= next_state_out;
            round     <= next_round;
            step      <= next_step;
            busy      <= next_busy;
            done      <= next_done;
            rc_acc0   <= next_rc_acc0;
            rc_acc1   <= next_rc_acc1;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence s_zero_go;
        go && (state_in == '0);
    endsequence

    sequence s_step0_end;
        running && (step == `LWCP_STEP_FIRST) && last_round;
    endsequence

    a_sc_source: assert property (
        (running && last_round) |=>
            state_out.e[7:0] == ($past(state_out.b[7:0]) ^
                                 $past(box_c[7:0]) ^ $past(k.sc0)))
        else $error("step constant not taken at last round");

    a_sc_step0: assert property (
        s_step0_end |-> (k.sc0 == `LWCP_KAT_SC0) &&
                        (k.sc1 == `LWCP_KAT_SC1) &&
                        (k.sc2 == `LWCP_KAT_SC2))
        else $error("step zero step constants wrong");

    a_rc_step0: assert property (
        s_step0_end |=> (rc_acc0 == `LWCP_KAT_RC0) &&
                        (rc_acc1 == `LWCP_KAT_RC1))
        else $error("step zero round constants wrong");

    a_box_first: assert property (
        s_zero_go |=> ##1 state_out.a == `LWCP_KAT_BOX1)
        else $error("box first round answer wrong");

    a_box_eighth: assert property (
        s_zero_go |=> ##8 state_out.c == `LWCP_KAT_BOX8)
        else $error("box eighth round answer wrong");

    a_perm_step1: assert property (
        s_zero_go |=> ##8 state_out.a == `LWCP_KAT_STEP1)
        else $error("first word after step one wrong");

    a_perm_final: assert property (
        s_zero_go |=> ##127 (!done ##1
            (done && !busy && state_out.a == `LWCP_KAT_FINAL)))
        else $error("final first word or done timing wrong");

    a_done_hold: assert property (
        (done && !start) |=> done && $stable(state_out))
        else $error("result not held after done");

endmodule

// ===== tb_top.sv
// self-checking bench for the permutation core: timing, holding, answers
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // signals and expected states
    // ------------------------------------------------------------
    logic                  mclk;
    logic                  rst;
    logic                  start;
    lwcp_pkg::lwcp_state_t state_in;
    logic                  busy;
    logic                  done;
    lwcp_pkg::lwcp_state_t state_out;
    int                    err_total;
    int                    comparisons;
    int                    pos;

    localparam logic [319:0] STEP1 = {64'hFFFFC7CAFFFFE776,
        64'h00003C9E00001C3A, 64'h00001C1E00000C2D,
        64'hFFFFDBD4FFFFEB67, 64'hFFFFC361FFFFE36A};
    localparam logic [319:0] FINAL = {64'h5C93691AD5060935,
        64'hDC19CE947EAD550D, 64'hAC12BEE1A64B670E,
        64'hF516E8BE1DFA60DA, 64'h409892A4E4CCBC15};
    localparam logic [319:0] ONES = {5{64'hFFFFFFFFFFFFFFFF}};

    lwcp_core dut_u (
        .mclk      (mclk),
        .rst       (rst),
        .start     (start),
        .state_in  (state_in),
        .busy      (busy),
        .done      (done),
        .state_out (state_out)
    );

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [319:0] got, input logic [319:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        if (err_total == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // pos counts rising edges since the edge that took start
    task automatic adv(input int n);
        while (pos < n) begin
            @(negedge mclk);
            pos++;
        end
    endtask

    task automatic launch(input logic [319:0] s);
        start = 1'b1;
        state_in = s;
        @(negedge mclk);
        pos = 0;
        start = 1'b0;
    endtask

    // zero state through all steps; poke tries a start while busy
    task automatic run_zero(input bit poke);
        launch(320'h0);
        chk(320'({busy, done}), 320'h2);
        chk(state_out, 320'h0);
        adv(1);
        chk(320'(state_out.a), 320'(64'hFFFFFFFF00000000));
        adv(8);
        chk(state_out, STEP1);
        chk(320'(state_out.c), 320'(64'h00001C1E00000C2D));
        chk(320'(state_out.a), 320'(64'hFFFFC7CAFFFFE776));
        if (poke) begin
            adv(50);
            start = 1'b1;
            state_in = ONES;
            @(negedge mclk);
            pos++;
            start = 1'b0;
        end
        while (done !== 1'b1 && pos < 200) begin
            @(negedge mclk);
            pos++;
        end
        if (pos >= 200) begin
            err_total++;
            end_of_test();
        end
        chk(320'(pos), 320'h80);
        chk(320'({busy, done}), 320'h1);
        chk(state_out, FINAL);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values();
        chk(320'({busy, done}), 320'h0);
        chk(state_out, 320'h0);
    endtask

    task automatic t_single_and_hold();
        run_zero(1'b0);
        state_in = ONES;
        repeat (6) @(negedge mclk);
        chk(320'({busy, done}), 320'h1);
        chk(state_out, FINAL);
    endtask

    // restart in the done cycle; the sequence must reload to all ones
    task automatic t_back_to_back();
        run_zero(1'b1);
        run_zero(1'b0);
    endtask

    task automatic t_mid_reset();
        launch(320'h0);
        adv(20);
        rst = 1'b1;
        @(negedge mclk);
        rst = 1'b0;
        chk(320'({busy, done}), 320'h0);
        chk(state_out, 320'h0);
        run_zero(1'b0);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        start = 1'b0;
        state_in = 320'h0;
        err_total = 0;
        comparisons = 0;
        pos = 0;
        repeat (8) @(negedge mclk);
        rst = 1'b0;
        t_reset_values();
        t_single_and_hold();
        t_back_to_back();
        t_mid_reset();
        end_of_test();
    end
endmodule
